// [design/baud_gen.sv]
// Baud rate generator with its AHB-Lite register file
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
module baud_gen
   import baud_gen_pkg::*;
(
   // Clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RESET_N,
   // AHB-Lite slave
   input wire baud_gen_pkg::ahb_req_t I_AHB,
   output baud_gen_pkg::ahb_rsp_t O_AHB,
   // Receiver idle flag and transmit shift-empty status
   input wire logic I_RECEIVER_IDLE_FLAG,
   input wire logic I_SHIFT_EMPTY,
   // Bit-rate tick
   output logic O_BAUD_TICK
);
   import baud_gen_pkg::*;

   `include "baud_gen_map.svh"

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      bus_state_t bus;
      logic [7:0] addr;
      logic [7:0] baud_control;
      logic [7:0] receive_status_control;
      logic [7:0] divisor_low;
      logic [7:0] divisor_high;
      logic [7:0] transmit_status_control;
      logic [15:0] tick_count;
      logic [31:0] rdata;
      logic clear;
      logic [2:0] idle_sync;
      logic idle;
      logic [2:0] empty_sync;
      logic empty;
   } gen_state_t;

   gen_state_t state_q;
   gen_state_t state_d;
   timer_cfg_t cfg;
   logic tick;
   logic sync_mode;
   logic high_speed;
   logic addr_phase;
   logic [7:0] wbyte;

   // ****************************************
   // Prescale selection
   // ****************************************
   assign sync_mode = state_q.transmit_status_control[`BIT_SYNC_MODE];
   assign high_speed = state_q.transmit_status_control[`BIT_HIGH_SPEED_SELECT];

   // Sync mode ignores high speed select
   always_comb begin
      cfg.enable = state_q.receive_status_control[`BIT_SERIAL_ENABLE];
      cfg.wide = state_q.baud_control[`BIT_WIDE_DIVIDER_SELECT];
      cfg.divisor = {state_q.divisor_high, state_q.divisor_low};
      if (sync_mode || (cfg.wide && high_speed)) begin
         cfg.prescale = PRE_DIV4;
      end else if (cfg.wide ^ high_speed) begin
         cfg.prescale = PRE_DIV16;
      end else begin
         cfg.prescale = PRE_DIV64;
      end
   end

   // ****************************************
   // Bus slave and register file
   // ****************************************
   assign addr_phase = I_AHB.hsel && I_AHB.hready && I_AHB.htrans[1];
   assign wbyte = I_AHB.hwdata[7:0];

   // Zero wait state answers; reads fetched at the address phase
   always_comb begin
      state_d = state_q;
      state_d.clear = 1'b0;
      state_d.bus = BUS_IDLE;
      // Three-stage pin synchronisers, change taken when stages 2 and 3 agree
      state_d.idle_sync = {state_q.idle_sync[1:0], I_RECEIVER_IDLE_FLAG};
      if (state_q.idle_sync[2] == state_q.idle_sync[1]) begin
         state_d.idle = state_q.idle_sync[2];
      end
      state_d.empty_sync = {state_q.empty_sync[1:0], I_SHIFT_EMPTY};
      if (state_q.empty_sync[2] == state_q.empty_sync[1]) begin
         state_d.empty = state_q.empty_sync[2];
      end
      if (tick) begin
         state_d.tick_count = state_q.tick_count + 16'd1;
      end
      // Write data phase
      if (state_q.bus == BUS_WRITE) begin
         if (state_q.addr == `ADDR_BAUD_CONTROL) begin
            state_d.baud_control = wbyte & `MASK_BAUD_CONTROL;
         end else if (state_q.addr == `ADDR_RECEIVE_STATUS_CONTROL) begin
            state_d.receive_status_control = wbyte & `MASK_RECEIVE_STATUS_CONTROL;
         end else if (state_q.addr == `ADDR_DIVISOR_LOW) begin
            state_d.divisor_low = wbyte;
            state_d.clear = 1'b1;
         end else if (state_q.addr == `ADDR_DIVISOR_HIGH) begin
            state_d.divisor_high = wbyte;
            state_d.clear = 1'b1;
         end else if (state_q.addr == `ADDR_TRANSMIT_STATUS_CONTROL) begin
            state_d.transmit_status_control = wbyte & `MASK_TRANSMIT_STATUS_CONTROL;
         end else if (state_q.addr == `ADDR_TICK_COUNT) begin
            // A tick landing in the clearing cycle is kept, not lost
            state_d.tick_count = {15'h0000, tick};
         end
      end
      // Address phase
      if (addr_phase) begin
         state_d.addr = I_AHB.haddr;
         state_d.bus = I_AHB.hwrite ? BUS_WRITE : BUS_READ;
         state_d.rdata = 32'h0000_0000;
         if (!I_AHB.hwrite) begin
            if (I_AHB.haddr == `ADDR_BAUD_CONTROL) begin
               state_d.rdata[7:0] = state_q.baud_control;
               state_d.rdata[`BIT_RECEIVER_IDLE_FLAG] = state_q.idle;
            end else if (I_AHB.haddr == `ADDR_RECEIVE_STATUS_CONTROL) begin
               state_d.rdata[7:0] = state_q.receive_status_control;
            end else if (I_AHB.haddr == `ADDR_DIVISOR_LOW) begin
               state_d.rdata[7:0] = state_q.divisor_low;
            end else if (I_AHB.haddr == `ADDR_DIVISOR_HIGH) begin
               state_d.rdata[7:0] = state_q.divisor_high;
            end else if (I_AHB.haddr == `ADDR_TRANSMIT_STATUS_CONTROL) begin
               state_d.rdata[7:0] = state_q.transmit_status_control;
               state_d.rdata[`BIT_SHIFT_EMPTY] = state_q.empty;
            end else if (I_AHB.haddr == `ADDR_TICK_COUNT) begin
               state_d.rdata[15:0] = state_q.tick_count;
            end
         end
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         state_q <= '0;
         state_q.baud_control <= `RST_BAUD_CONTROL;
         state_q.receive_status_control <= `RST_RECEIVE_STATUS_CONTROL;
         state_q.divisor_low <= `RST_DIVISOR;
         state_q.divisor_high <= `RST_DIVISOR;
         state_q.transmit_status_control <= `RST_TRANSMIT_STATUS_CONTROL;
         state_q.idle_sync <= 3'b111;
         state_q.idle <= 1'b1;
         state_q.empty_sync <= 3'b111;
         state_q.empty <= 1'b1;
      end else begin
         state_q <= state_d;
      end
   end

   // Always ready, always OKAY
   assign O_AHB.hreadyout = 1'b1;
   assign O_AHB.hresp = 1'b0;
   assign O_AHB.hrdata = state_q.rdata;

   // ****************************************
   // Timer
   // ****************************************
   baud_timer u_timer (
      .i_clk(I_CORE_CLK),
      .i_reset_n(I_RESET_N),
      .i_cfg(cfg),
      .i_clear(state_q.clear),
      .o_tick(tick)
   );

   assign O_BAUD_TICK = tick;

   // ****************************************
   // Checks
   // ****************************************
   logic [21:0] gap_q;
   logic [21:0] expect_gap;
   // Settings one cycle back, and whether they held still since the last tick;
   // a period that straddles a change is never judged
   timer_cfg_t cfg_q;
   logic armed_q;
   logic [7:0] pre_n;
   always_comb begin
      case (cfg.prescale)
         PRE_DIV64: pre_n = `PRESCALE_SLOW;
         PRE_DIV16: pre_n = `PRESCALE_MID;
         default: pre_n = `PRESCALE_FAST;
      endcase
      expect_gap = 22'({6'h00, (cfg.wide ? cfg.divisor : {8'h00, cfg.divisor[7:0]})} + 22'd1)
         * 22'(pre_n);
   end
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         gap_q <= '0;
         cfg_q <= '0;
         armed_q <= 1'b0;
      end else begin
         cfg_q <= cfg;
         // The timer restarts on a divisor write, so the gap restarts with it
         if (tick || state_q.clear) begin
            gap_q <= 22'd1;
         end else begin
            gap_q <= gap_q + 22'd1;
         end
         // Any settings change disarms; a coincident tick does not re-arm
         if (state_q.clear || cfg != cfg_q) begin
            armed_q <= 1'b0;
         end else if (tick) begin
            armed_q <= 1'b1;
         end
      end
   end

   // Spacing judged only between two ticks under unchanged settings
   property p_period;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      tick && armed_q && cfg == cfg_q |-> gap_q == expect_gap;
   endproperty
   a_period: assert property (p_period) else $error("tick period wrong");
   property p_sync_fast;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      sync_mode |-> cfg.prescale == PRE_DIV4;
   endproperty
   a_sync_fast: assert property (p_sync_fast) else $error("sync prescale wrong");
   property p_slow;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      !sync_mode && !cfg.wide && !high_speed |-> cfg.prescale == PRE_DIV64;
   endproperty
   a_slow: assert property (p_slow) else $error("slow prescale wrong");
   property p_mid;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      !sync_mode && (cfg.wide ^ high_speed) |-> cfg.prescale == PRE_DIV16;
   endproperty
   a_mid: assert property (p_mid) else $error("mid prescale wrong");
   property p_clear;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      state_q.bus == BUS_WRITE && (state_q.addr == `ADDR_DIVISOR_LOW
         || state_q.addr == `ADDR_DIVISOR_HIGH) |=> state_q.clear ##1 !tick;
   endproperty
   a_clear: assert property (p_clear) else $error("divisor write did not clear");
   property p_narrow;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      $rose(I_RESET_N) |-> !cfg.wide;
   endproperty
   a_narrow: assert property (p_narrow) else $error("not narrow after reset");
   // Narrow count never climbs past the low byte, whatever the high byte holds
   property p_high_ignored;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      armed_q && cfg == cfg_q && !cfg.wide
         |-> u_timer.state_q.count <= {8'h00, cfg.divisor[7:0]};
   endproperty
   a_high_ignored: assert property (p_high_ignored) else $error("high byte used");
   // Wide period built from the two registers, high byte on top
   property p_pair;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      tick && armed_q && cfg == cfg_q && cfg.wide |-> gap_q ==
         22'(({6'h00, state_q.divisor_high, state_q.divisor_low} + 22'd1) * 22'(pre_n));
   endproperty
   a_pair: assert property (p_pair) else $error("divisor pair order wrong");
   property p_disabled;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      !cfg.enable ##1 !cfg.enable |-> !tick;
   endproperty
   a_disabled: assert property (p_disabled) else $error("tick while disabled");
   // Restart is seen inside the timer, not only at its tick
   property p_restart;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      state_q.clear |=> u_timer.state_q.count == 16'h0000 && u_timer.state_q.pre == 8'h00;
   endproperty
   a_restart: assert property (p_restart) else $error("timer not restarted");
   // Shortest period is four clocks, so a tick never lasts two
   property p_pulse;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      tick |=> !tick;
   endproperty
   a_pulse: assert property (p_pulse) else $error("tick longer than one cycle");
   // Tick counter follows the ticks unless software is clearing it
   property p_count;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      tick && !(state_q.bus == BUS_WRITE && state_q.addr == `ADDR_TICK_COUNT)
         |=> state_q.tick_count == $past(state_q.tick_count) + 16'd1;
   endproperty
   a_count: assert property (p_count) else $error("tick count missed a tick");
   // Receiver idle flag moves only to a value two sync stages agree on
   property p_filter;
      @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
      $changed(state_q.idle) |-> $past(state_q.idle_sync[2]) == $past(state_q.idle_sync[1])
         && state_q.idle == $past(state_q.idle_sync[2]);
   endproperty
   a_filter: assert property (p_filter) else $error("idle flag taken before it settled");
   // Main scenarios: a judged period, wide and sync ticks, a divisor restart
   c_tick: cover property (@(posedge I_CORE_CLK) tick && armed_q);
   c_wide: cover property (@(posedge I_CORE_CLK) tick && cfg.wide);
   c_sync: cover property (@(posedge I_CORE_CLK) tick && sync_mode);
   c_clear: cover property (@(posedge I_CORE_CLK) state_q.clear);

endmodule

// [common/baud_gen_map.svh]
// Register offsets, field positions, reset values and timing counts of the baud generator
`ifndef BAUD_GEN_MAP_SVH
`define BAUD_GEN_MAP_SVH

// Byte addresses of the registers
`define ADDR_BAUD_CONTROL 8'h00
`define ADDR_RECEIVE_STATUS_CONTROL 8'h04
`define ADDR_DIVISOR_LOW 8'h08
`define ADDR_DIVISOR_HIGH 8'h0c
`define ADDR_TRANSMIT_STATUS_CONTROL 8'h10
`define ADDR_TICK_COUNT 8'h14

// Field positions
`define BIT_RECEIVER_IDLE_FLAG 6
`define BIT_WIDE_DIVIDER_SELECT 3
`define BIT_SERIAL_ENABLE 7
`define BIT_SYNC_MODE 4
`define BIT_HIGH_SPEED_SELECT 2
`define BIT_SHIFT_EMPTY 1

// Writable masks
`define MASK_BAUD_CONTROL 8'h1b
`define MASK_RECEIVE_STATUS_CONTROL 8'hf8
`define MASK_TRANSMIT_STATUS_CONTROL 8'hfd

// Reset values
`define RST_BAUD_CONTROL 8'h00
`define RST_RECEIVE_STATUS_CONTROL 8'h00
`define RST_DIVISOR 8'h00
`define RST_TRANSMIT_STATUS_CONTROL 8'h00

// Prescale divide counts
`define PRESCALE_SLOW 8'd64
`define PRESCALE_MID 8'd16
`define PRESCALE_FAST 8'd4

`endif

// [common/baud_gen_pkg.sv]
// Types shared by the baud generator files
package baud_gen_pkg;

   // AHB-Lite slave side request signals
   typedef struct packed {
      logic hsel;
      logic [7:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
      logic [31:0] hwdata;
   } ahb_req_t;

   // AHB-Lite slave answer signals
   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } ahb_rsp_t;

   // Prescale selection
   typedef enum logic [1:0] {
      PRE_DIV64,
      PRE_DIV16,
      PRE_DIV4
   } prescale_t;

   // Bus data phase states
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WRITE,
      BUS_READ
   } bus_state_t;

   // Settings that steer the timer
   typedef struct packed {
      logic enable;
      logic wide;
      prescale_t prescale;
      logic [15:0] divisor;
   } timer_cfg_t;

endpackage

// [design/baud_timer.sv]
// Prescaler and reloading divisor timer that makes the bit-rate tick
`timescale 1ns/10ps
module baud_timer
   import baud_gen_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Configuration
   input wire baud_gen_pkg::timer_cfg_t i_cfg,
   input wire logic i_clear,
   // Tick
   output logic o_tick
);
   import baud_gen_pkg::*;

   `include "baud_gen_map.svh"

   typedef struct packed {
      logic [7:0] pre;
      logic [15:0] count;
      logic tick;
   } timer_state_t;

   timer_state_t state_q;
   timer_state_t state_d;
   logic [7:0] pre_last;
   logic [15:0] period;
   logic pre_pulse;

   // Prescale terminal count
   always_comb begin
      case (i_cfg.prescale)
         PRE_DIV64: pre_last = `PRESCALE_SLOW - 8'd1;
         PRE_DIV16: pre_last = `PRESCALE_MID - 8'd1;
         default: pre_last = `PRESCALE_FAST - 8'd1;
      endcase
   end

   // Narrow mode ignores the high divisor byte
   assign period = i_cfg.wide ? i_cfg.divisor : {8'h00, i_cfg.divisor[7:0]};
   assign pre_pulse = (state_q.pre >= pre_last);

   // Free-running count, cleared by a divisor write
   always_comb begin
      state_d = state_q;
      state_d.tick = 1'b0;
      if (!i_cfg.enable || i_clear) begin
         state_d.pre = 8'h00;
         state_d.count = 16'h0000;
      end else if (pre_pulse) begin
         state_d.pre = 8'h00;
         if (state_q.count >= period) begin
            state_d.count = 16'h0000;
            state_d.tick = 1'b1;
         end else begin
            state_d.count = state_q.count + 16'd1;
         end
      end else begin
         state_d.pre = state_q.pre + 8'd1;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign o_tick = state_q.tick;

endmodule

// [tb/test_baud_gen.sv]
// Self-checking testbench of the baud rate generator with its register file
`timescale 1ns/10ps
`include "baud_gen_map.svh"
module test_baud_gen;
   import baud_gen_pkg::*;
   // ****************************************
   // Signals, clock and tick monitor
   // ****************************************
   logic core_clk;
   logic reset_n;
   logic idle_flag;
   logic shift_empty;
   logic baud_tick;
   ahb_req_t drv;
   ahb_req_t req;
   ahb_rsp_t rsp;
   int error_cnt = 0;
   int n_tests = 0;
   int seed = 32'h9c33cfa0;
   int cyc = 0;
   int nticks = 0;
   int t_last = 0;
   int t_prev = 0;
   // Register table: address, writable mask, status bits while both inputs are high
   logic [7:0] adr [7] = '{`ADDR_BAUD_CONTROL, `ADDR_TICK_COUNT, `ADDR_DIVISOR_LOW,
      `ADDR_DIVISOR_HIGH, `ADDR_TRANSMIT_STATUS_CONTROL, 8'h18, `ADDR_RECEIVE_STATUS_CONTROL};
   logic [7:0] msk [7] = '{8'h1b, 8'h00, 8'hff, 8'hff, 8'hfd, 8'h00, 8'hf8};
   logic [7:0] sts [7] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
   logic [7:0] wd [7];

   // Single slave, so its own ready is the bus ready
   always_comb begin
      req = drv;
      req.hready = rsp.hreadyout;
   end

   baud_gen dut_u (
      .I_CORE_CLK(core_clk),
      .I_RESET_N(reset_n),
      .I_AHB(req),
      .O_AHB(rsp),
      .I_RECEIVER_IDLE_FLAG(idle_flag),
      .I_SHIFT_EMPTY(shift_empty),
      .O_BAUD_TICK(baud_tick)
   );

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Counted on the falling edge so each tick is seen exactly once, settled
   always @(negedge core_clk) begin
      cyc++;
      if (baud_tick === 1'b1) begin
         nticks++;
         t_prev = t_last;
         t_last = cyc;
      end
   end

   // ****************************************
   // Tasks and expectation functions
   // ****************************************
   task automatic close_out();
      $display("Counts: comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Bounded wait for hready sampled high at a rising edge
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (rsp.hreadyout !== 1'b1 && k < 20);
      if (rsp.hreadyout !== 1'b1) begin
         error_cnt++;
         close_out();
      end
   endtask

   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
      output logic [31:0] rd);
      drv.hsel <= 1'b1;
      drv.haddr <= a;
      drv.htrans <= 2'b10;
      drv.hwrite <= w;
      drv.hsize <= 3'b010;
      wait_rdy();
      drv.hsel <= 1'b0;
      drv.htrans <= 2'b00;
      drv.hwdata <= {24'h0, d};
      wait_rdy();
      rd = rsp.hrdata;
      check({31'h0, rsp.hresp}, 32'h0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      xfer(a, 1'b1, d, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(a, 1'b0, 8'h00, r);
      check(r, exp);
   endtask

   task automatic wait_ticks(input int n, input int bound);
      int k;
      int n0;
      k = 0;
      n0 = nticks;
      while (nticks < n0 + n && k < bound) begin
         @(posedge core_clk);
         k++;
      end
      if (nticks < n0 + n) begin
         error_cnt++;
         close_out();
      end
   endtask

   // Prescale chosen by sync, wide and high speed bits
   function automatic int exp_p(input logic sy, input logic wi, input logic hs);
      if (sy || (wi && hs)) return 4;
      if (wi || hs) return 16;
      return 64;
   endfunction

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic sy;
      logic wi;
      logic hs;
      logic [7:0] lo;
      logic [7:0] hi;
      int p;
      int n;
      int c0;
      int n0;
      drv = '0;
      reset_n = 1'b0;
      idle_flag = 1'b1;
      shift_empty = 1'b1;
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      // Outputs quiet after reset, looked at once settled
      @(negedge core_clk);
      check(rsp.hrdata, 32'h0);
      check({31'h0, baud_tick}, 32'h0);
      @(posedge core_clk);
      // Reset values, then random writes read back through the masks
      for (int i = 0; i < 7; i++) rd_chk(adr[i], {24'h0, sts[i]});
      for (int i = 0; i < 7; i++) begin
         wd[i] = 8'($random(seed));
         wr(adr[i], wd[i]);
         rd_chk(adr[i], {24'h0, (wd[i] & msk[i]) | sts[i]});
      end
      idle_flag <= 1'b0;
      shift_empty <= 1'b0;
      repeat (6) @(posedge core_clk);
      rd_chk(adr[0], {24'h0, wd[0] & msk[0]});
      rd_chk(adr[4], {24'h0, wd[4] & msk[4]});
      $display("Test registers done");
      // Every mode combination; wide high byte only where the period stays short
      for (int m = 0; m < 8; m++) begin
         sy = m[2];
         wi = m[1];
         hs = m[0];
         p = exp_p(sy, wi, hs);
         lo = (m == 5) ? 8'hff : (8'($random(seed)) & 8'h07);
         hi = wi ? ((p == 4) ? 8'h01 : 8'h00) : 8'($random(seed));
         n = wi ? {hi, lo} : lo;
         wr(`ADDR_TRANSMIT_STATUS_CONTROL, {3'b000, sy, 1'b0, hs, 2'b00});
         wr(`ADDR_BAUD_CONTROL, {4'h0, wi, 3'b000});
         wr(`ADDR_DIVISOR_HIGH, hi);
         wr(`ADDR_DIVISOR_LOW, lo);
         wr(`ADDR_RECEIVE_STATUS_CONTROL, 8'h80);
         wait_ticks(3, 4 * p * (n + 1) + 100);
         check(t_last - t_prev, p * (n + 1));
      end
      $display("Test rates done");
      // A write to either divisor register mid-count restarts the period
      wr(`ADDR_TRANSMIT_STATUS_CONTROL, 8'h10);
      wr(`ADDR_BAUD_CONTROL, 8'h00);
      for (int j = 0; j < 2; j++) begin
         wr(`ADDR_DIVISOR_LOW, 8'd200);
         wait_ticks(1, 2000);
         repeat (400) @(posedge core_clk);
         if (j == 0) wr(`ADDR_DIVISOR_LOW, 8'd9);
         else wr(`ADDR_DIVISOR_HIGH, 8'h55);
         c0 = cyc;
         n = (j == 0) ? 9 : 200;
         wait_ticks(1, 2000);
         p = t_last - c0 - 4 * (n + 1);
         check({31'h0, p >= -4 && p <= 4}, 32'h1);
      end
      $display("Test divisor clear done");
      // Disabled timer is silent; tick count matches ticks seen
      wr(`ADDR_DIVISOR_LOW, 8'd9);
      wr(`ADDR_RECEIVE_STATUS_CONTROL, 8'h00);
      wr(`ADDR_TICK_COUNT, 8'h00);
      n0 = nticks;
      repeat (300) @(posedge core_clk);
      check(32'(nticks - n0), 32'h0);
      rd_chk(`ADDR_TICK_COUNT, 32'h0);
      wr(`ADDR_RECEIVE_STATUS_CONTROL, 8'h80);
      wait_ticks(5, 1000);
      wr(`ADDR_RECEIVE_STATUS_CONTROL, 8'h00);
      repeat (3) @(posedge core_clk);
      rd_chk(`ADDR_TICK_COUNT, 32'(nticks - n0));
      $display("Test enable and count done");
      close_out();
   end
endmodule
